// ==== rxepf_params.svh ====
`ifndef RXEPF_PARAMS_SVH
`define RXEPF_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define RXEPF_CMD_OFS       16'h2100
`define RXEPF_PTR_OFS       16'h2104
`define RXEPF_STA_LO_OFS    16'h2110
`define RXEPF_STA_HI_OFS    16'h2114
`define RXEPF_MEM_SEL       2'b11

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RXEPF_FINISH_BIT    31
`define RXEPF_PTR_RST       4'h0
`define RXEPF_STA_RST       48'h0000_0000_0000

// ----------------------------------------------------------------------
// Header comparison constants and byte positions
// ----------------------------------------------------------------------
`define RXEPF_BCAST_BYTE    8'hFF
`define RXEPF_ETYPE_HI      8'h08
`define RXEPF_ETYPE_LO      8'h00
`define RXEPF_VER_HL        8'h45
`define RXEPF_PROTO_ICMP    8'h01
`define RXEPF_POS_DST_LAST  5'h05
`define RXEPF_POS_ETYPE_HI  5'h0C
`define RXEPF_POS_ETYPE_LO  5'h0D
`define RXEPF_POS_VER_HL    5'h0E
`define RXEPF_POS_PROTO     5'h17
`define RXEPF_ACCEPT_CNT    5'h18

// ----------------------------------------------------------------------
// Slot memory geometry
// ----------------------------------------------------------------------
`define RXEPF_SLOT_LAST     11'h7FF
`define RXEPF_SLOT_COUNT    4'h8

`endif

// ==== rxepf_pkg.sv ====
package rxepf_pkg;

  // Frame reception states, one-hot
  typedef enum logic [3:0] {
    rxepf_idle  = 4'b0001,
    rxepf_hdr   = 4'b0010,
    rxepf_store = 4'b0100,
    rxepf_drop  = 4'b1000
  } rxepf_state_t;

  typedef logic [3:0]  rxepf_ptr_t;
  typedef logic [13:0] rxepf_waddr_t;
  typedef logic [11:0] rxepf_raddr_t;

endpackage

// ==== rxepf_sync.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Three-stage pin synchroniser; a bit changes once stages two and three agree
// ----------------------------------------------------------------------
module rxepf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // Bits where the two settled stages match
  assign agree = ~(stage2 ^ stage3);

  // Stage one is read only by stage two
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      level_out <= '0;
    end else begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      level_out <= (agree & stage3) | (~agree & level_out);
    end
  end
endmodule // rxepf_sync

// ==== rxepf_slot_mem.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// 16 KB slot memory: byte write port, 32-bit read port
// ----------------------------------------------------------------------
module rxepf_slot_mem (
  input  wire logic                   ref_clk_in,
  input  wire logic                   wr_en_in,
  input  wire rxepf_pkg::rxepf_waddr_t wr_addr_in,
  input  wire logic [7:0]             wr_data_in,
  input  wire rxepf_pkg::rxepf_raddr_t rd_addr_in,
  output logic [31:0]                 rd_data_out
);
  import rxepf_pkg::*;

  // One byte lane per generate pass; byte 0 of a word sits in bits 7:0
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    logic [7:0] lane_mem [0:4095];
    wire        lane_we = wr_en_in && (wr_addr_in[1:0] == 2'(lane));

    always_ff @(posedge ref_clk_in) begin
      if (lane_we) begin
        lane_mem[wr_addr_in[13:2]] <= wr_data_in;
      end
      rd_data_out[lane*8 +: 8] <= lane_mem[rd_addr_in];
    end
  end
endmodule // rxepf_slot_mem

// ==== rxepf_top.sv ====
`timescale 1ns/1ns
`include "rxepf_params.svh"

module rxepf_top (
  input  wire logic                 ref_clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 rx_line_clock_in,
  input  wire logic [7:0]           rx_data_in,
  input  wire logic                 rx_valid_in,
  input  wire logic                 rx_sop_in,
  input  wire logic                 rx_eop_in,
  input  wire logic [15:0]          reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [31:0]               reg_rdata_out,
  output rxepf_pkg::rxepf_ptr_t     slot_write_pointer_out,
  output logic                      slots_full_flag_out
);
  import rxepf_pkg::*;

  // --------------------------------------------------------------------
  // Line sampling
  // --------------------------------------------------------------------
  // The line pins arrive from the receive clock domain. Rather than a second
  // clock tree, the system clock oversamples them; this needs the line
  // period to span at least eight system clocks, which a slow port allows.
  // Synchronised copies of the line pins
  logic [11:0] line_level;
  logic        line_clk_d;
  wire         line_clk_f  = line_level[11];
  wire  [7:0]  line_data   = line_level[7:0];
  wire         line_valid  = line_level[8];
  wire         line_sop    = line_level[9];
  wire         line_eop    = line_level[10];

  // Clock and data share one synchroniser so they keep equal delay
  rxepf_sync #(
    .WIDTH (12)
  ) u_line_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     ({rx_line_clock_in, rx_eop_in, rx_sop_in, rx_valid_in, rx_data_in}),
    .level_out  (line_level)
  );

  // Sample on the falling line edge: data launched at the rising edge are
  // settled there, half a line period away from any change
  wire line_fall = line_clk_d & ~line_clk_f;
  wire byte_stb  = line_fall & line_valid;

  // Previous line clock level; its reset value is the idle low level of the
  // pin, so no false falling edge is seen just after reset
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      line_clk_d <= 1'b0;
    end else begin
      line_clk_d <= line_clk_f;
    end
  end

  // --------------------------------------------------------------------
  // CPU-side registers
  // --------------------------------------------------------------------
  // Programmed station address halves, pointers and the finish flag;
  // the station address is write-only, so software keeps its own copy
  logic [31:0]  sta_lo;
  logic [15:0]  sta_hi;
  rxepf_ptr_t   rd_ptr;
  rxepf_ptr_t   wr_ptr;
  logic         finish_flag;
  logic         frame_done;

  wire [47:0] station_address_value = {sta_hi, sta_lo};

  // Address decode; memory reads take the top quarter of the map
  wire hit_cmd   = (reg_addr_in == `RXEPF_CMD_OFS);
  wire hit_ptr   = (reg_addr_in == `RXEPF_PTR_OFS);
  wire hit_sta_l = (reg_addr_in == `RXEPF_STA_LO_OFS);
  wire hit_sta_h = (reg_addr_in == `RXEPF_STA_HI_OFS);
  wire hit_mem   = (reg_addr_in[15:14] == `RXEPF_MEM_SEL);

  // Software clears the finish flag by writing a one to its bit
  wire finish_clr = reg_wr_in & hit_cmd & reg_wdata_in[`RXEPF_FINISH_BIT];

  // Register writes; a frame completing in the clearing cycle keeps the flag
  // The finish flag records that at least one frame has been stored
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      {sta_hi, sta_lo} <= `RXEPF_STA_RST;
      rd_ptr      <= `RXEPF_PTR_RST;
      finish_flag <= 1'b0;
    end else begin
      if (reg_wr_in && hit_sta_l) begin
        sta_lo <= reg_wdata_in;
      end
      if (reg_wr_in && hit_sta_h) begin
        sta_hi <= reg_wdata_in[15:0];
      end
      if (reg_wr_in && hit_ptr) begin
        rd_ptr <= reg_wdata_in[3:0];
      end
      finish_flag <= frame_done | (finish_flag & ~finish_clr);
    end
  end

  // --------------------------------------------------------------------
  // Register read path
  // --------------------------------------------------------------------
  // Read data are registered; the memory word comes out of its own flops
  logic [31:0] reg_q;
  logic        mem_sel_q;
  logic [31:0] mem_q;
  logic [31:0] next_reg_q;

  // Write-only and unmapped addresses read as zero
  assign next_reg_q = hit_cmd ? {finish_flag, 31'h0000_0000} :
                      hit_ptr ? {28'h000_0000, wr_ptr} :
                                32'h0000_0000;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      reg_q     <= 32'h0000_0000;
      mem_sel_q <= 1'b0;
    end else begin
      reg_q     <= reg_rd_in ? next_reg_q : 32'h0000_0000;
      mem_sel_q <= reg_rd_in & hit_mem;
    end
  end

  // Both sources are flops; the select only steers them
  assign reg_rdata_out = mem_sel_q ? mem_q : reg_q;

  // --------------------------------------------------------------------
  // Ring pointers
  // --------------------------------------------------------------------
  // Both pointers live in the system clock domain, so the full compare
  // needs no gray coding. Four bits tell a full ring from an empty one;
  // software must not write a read pointer that runs ahead of the write
  // pointer, or the ring looks fuller than it is.
  wire [3:0] ptr_diff = wr_ptr - rd_ptr;
  wire       full     = (ptr_diff == `RXEPF_SLOT_COUNT);

  assign slot_write_pointer_out = wr_ptr;
  assign slots_full_flag_out    = full;

  // --------------------------------------------------------------------
  // Header filter
  // --------------------------------------------------------------------
  // Filter state, header position counter and destination trackers; the
  // position counter parks at its accept value for the body of a frame
  rxepf_state_t state;
  rxepf_state_t next_state;
  logic [4:0]   header_check_state;
  logic [4:0]   next_hcs;
  logic [10:0]  byte_cnt;
  logic         dst_sta_ok;
  logic         dst_bc_ok;
  logic [7:0]   sta_byte;
  logic         byte_pass;
  logic         next_dst_sta;
  logic         next_dst_bc;
  logic         store_write_enable;

  // Position of the current byte; start of frame always counts from zero
  wire [4:0] pos = line_sop ? 5'h00 : header_check_state;
  wire       in_dst = (pos <= `RXEPF_POS_DST_LAST);

  // Station byte for this position, most significant byte first on the wire
  always_comb begin
    case (pos[2:0])
      3'h0:    sta_byte = station_address_value[47:40];
      3'h1:    sta_byte = station_address_value[39:32];
      3'h2:    sta_byte = station_address_value[31:24];
      3'h3:    sta_byte = station_address_value[23:16];
      3'h4:    sta_byte = station_address_value[15:8];
      default: sta_byte = station_address_value[7:0];
    endcase
  end

  // Destination tracking: either candidate may stay alive across six bytes
  wire sta_now = (line_sop | dst_sta_ok) & (line_data == sta_byte);
  wire bc_now  = (line_sop | dst_bc_ok) & (line_data == `RXEPF_BCAST_BYTE);

  // Per-byte check against the fixed constants
  // Positions not listed are passed through unchecked
  always_comb begin
    next_dst_sta = dst_sta_ok;
    next_dst_bc  = dst_bc_ok;
    byte_pass    = 1'b1;
    if (in_dst) begin
      next_dst_sta = sta_now;
      next_dst_bc  = bc_now;
      byte_pass    = sta_now | bc_now;
    end else begin
      case (pos)
        `RXEPF_POS_ETYPE_HI: byte_pass = (line_data == `RXEPF_ETYPE_HI);
        `RXEPF_POS_ETYPE_LO: byte_pass = (line_data == `RXEPF_ETYPE_LO);
        `RXEPF_POS_VER_HL:   byte_pass = (line_data == `RXEPF_VER_HL);
        `RXEPF_POS_PROTO:    byte_pass = (line_data == `RXEPF_PROTO_ICMP);
        default:             byte_pass = 1'b1;
      endcase
    end
  end

  // Frame walks: header bytes are checked, then the body is stored
  wire live_hdr   = line_sop ? ~full : (state == rxepf_hdr);
  wire in_accept  = ~line_sop & (state == rxepf_store);
  // A frame that would spill past its slot is dropped; the count left by an
  // earlier oversize frame is ignored at a new start of frame
  wire slot_over  = ~line_sop & (byte_cnt == `RXEPF_SLOT_LAST) & ~line_eop;
  wire hdr_done   = (pos == `RXEPF_POS_PROTO);

  // Next state, counter and write decision
  always_comb begin
    next_state         = state;
    next_hcs           = header_check_state;
    store_write_enable = 1'b0;
    frame_done         = 1'b0;
    if (byte_stb) begin
      // Header bytes: every checked byte must pass, or the frame is dropped
      if (live_hdr) begin
        if (!byte_pass || slot_over) begin
          next_state = rxepf_drop;
          next_hcs   = 5'h00;
        end else begin
          store_write_enable = 1'b1;
          next_hcs   = hdr_done ? `RXEPF_ACCEPT_CNT : pos + 5'h01;
          next_state = hdr_done ? rxepf_store : rxepf_hdr;
        end
      end else if (in_accept) begin
        // Body bytes of an accepted frame go straight to the slot
        if (slot_over) begin
          next_state = rxepf_drop;
          next_hcs   = 5'h00;
        end else begin
          store_write_enable = 1'b1;
          next_hcs           = `RXEPF_ACCEPT_CNT;
        end
      end else begin
        // Stray bytes, or a frame that met a full ring, are thrown away
        next_state = rxepf_drop;
        next_hcs   = 5'h00;
      end
      if (line_eop) begin
        // Only a frame still accepted at its last byte commits its slot
        frame_done = store_write_enable & (next_state == rxepf_store);
        next_state = rxepf_idle;
        next_hcs   = 5'h00;
      end
    end
  end

  // Filter state; a new start of frame abandons an unfinished one
  // Trackers move only with a byte, so idle cycles keep their verdict
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state              <= rxepf_idle;
      header_check_state <= 5'h00;
      dst_sta_ok         <= 1'b0;
      dst_bc_ok          <= 1'b0;
    end else begin
      state              <= next_state;
      header_check_state <= next_hcs;
      if (byte_stb) begin
        dst_sta_ok <= next_dst_sta;
        dst_bc_ok  <= next_dst_bc;
      end
    end
  end

  // --------------------------------------------------------------------
  // Address controller
  // --------------------------------------------------------------------
  // Write port flops: the memory sees one registered byte per stored byte
  logic        mem_we;
  rxepf_waddr_t mem_waddr;
  logic [7:0]  mem_wdata;

  // Byte offset inside the slot restarts with each frame
  wire [10:0] cur_off = line_sop ? 11'h000 : byte_cnt;

  // The pointer moves only once the last byte has been issued
  // Header bytes of a frame later rejected land only in the free slot,
  // which stays invisible because the pointer does not move
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      byte_cnt  <= 11'h000;
      wr_ptr    <= `RXEPF_PTR_RST;
      mem_we    <= 1'b0;
      mem_waddr <= 14'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_we <= store_write_enable;
      if (store_write_enable) begin
        mem_waddr <= {wr_ptr[2:0], cur_off};
        mem_wdata <= line_data;
        byte_cnt  <= cur_off + 11'h001;
      end
      if (frame_done) begin
        wr_ptr   <= wr_ptr + 4'h1;
        byte_cnt <= 11'h000;
      end
    end
  end

  // --------------------------------------------------------------------
  // Slot memory
  // --------------------------------------------------------------------
  // The read port follows the bus address on every cycle, so a memory read
  // has its word ready in the cycle after the strobe, as for a register
  rxepf_slot_mem u_slot_mem (
    .ref_clk_in  (ref_clk_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (mem_waddr),
    .wr_data_in  (mem_wdata),
    .rd_addr_in  (reg_addr_in[13:2]),
    .rd_data_out (mem_q)
  );

endmodule // rxepf_top

// ==== rxepf_top_assertions.sv ====
`timescale 1ns/1ns
`include "rxepf_params.svh"

// ----------------------------------------
// Port-level checks of the receive filter
// ----------------------------------------
module rxepf_top_assertions (
  input wire logic                  ref_clk_in,
  input wire logic                  sys_rst_in,
  input wire logic                  rx_line_clock_in,
  input wire logic [7:0]            rx_data_in,
  input wire logic                  rx_valid_in,
  input wire logic                  rx_sop_in,
  input wire logic                  rx_eop_in,
  input wire logic [15:0]           reg_addr_in,
  input wire logic [31:0]           reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [31:0]           reg_rdata_out,
  input wire rxepf_pkg::rxepf_ptr_t slot_write_pointer_out,
  input wire logic                  slots_full_flag_out
);
  import rxepf_pkg::*;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Decoded strobes; the full flag may only fall after a pointer write, and rise after one or a write pointer step
  wire ptr_wr = reg_wr_in && (reg_addr_in == `RXEPF_PTR_OFS);
  wire ptr_rd = reg_rd_in && (reg_addr_in == `RXEPF_PTR_OFS);
  wire cmd_rd = reg_rd_in && (reg_addr_in == `RXEPF_CMD_OFS);
  wire wo_rd  = reg_rd_in && (reg_addr_in == `RXEPF_STA_LO_OFS
                || reg_addr_in == `RXEPF_STA_HI_OFS || reg_addr_in == 16'h2108);

  chk_reset_ptr_zero: assert property (
    $fell(sys_rst_in) |-> slot_write_pointer_out == 4'h0 && !slots_full_flag_out)
    else $error("pointer or full set after reset");
  chk_ptr_step_one: assert property (
    !$stable(slot_write_pointer_out)
      |-> slot_write_pointer_out == $past(slot_write_pointer_out) + 4'h1)
    else $error("write pointer moved by other than one");
  chk_full_holds_ptr: assert property (
    slots_full_flag_out |=> $stable(slot_write_pointer_out))
    else $error("frame stored while full");
  chk_full_rise_cause: assert property (
    $rose(slots_full_flag_out)
      |-> $changed(slot_write_pointer_out) || $past(ptr_wr) || $past(ptr_wr, 2))
    else $error("full rose without cause");
  chk_full_fall_cause: assert property (
    $fell(slots_full_flag_out) |-> $past(ptr_wr) || $past(ptr_wr, 2))
    else $error("full fell without pointer write");
  chk_ptr_readback: assert property (
    ptr_rd |=> reg_rdata_out == {28'h0, $past(slot_write_pointer_out)})
    else $error("pointer read mismatch");
  chk_wo_read_zero: assert property (
    wo_rd |=> reg_rdata_out == 32'h0000_0000)
    else $error("write-only or unmapped read not zero");
  chk_cmd_low_zero: assert property (
    cmd_rd |=> reg_rdata_out[30:0] == 31'h0000_0000)
    else $error("command read low bits not zero");

  cov_ptr_step: cover property ($changed(slot_write_pointer_out));
  cov_full_rise: cover property ($rose(slots_full_flag_out));
  cov_full_fall: cover property ($fell(slots_full_flag_out));
endmodule // rxepf_top_assertions

bind rxepf_top rxepf_top_assertions rxepf_top_assertions_i (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .rx_line_clock_in(rx_line_clock_in),
  .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_sop_in(rx_sop_in),
  .rx_eop_in(rx_eop_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .slot_write_pointer_out(slot_write_pointer_out),
  .slots_full_flag_out(slots_full_flag_out));

// ==== rxepf_mac_model.sv ====
`timescale 1ns/1ns

// ----------------------------------------
// Receive MAC model, line clock stops between frames
// ----------------------------------------
module rxepf_mac_model (
  output logic       rx_line_clock_out,
  output logic [7:0] rx_data_out,
  output logic       rx_valid_out,
  output logic       rx_sop_out,
  output logic       rx_eop_out
);
  initial begin
    rx_line_clock_out = 1'b0;
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_sop_out = 1'b0;
    rx_eop_out = 1'b0;
  end

  // One 125 ns line period; launch after the rise, hold across the fall
  task automatic line_cycle(input logic [7:0] d, input logic v, input logic s,
                            input logic e);
    rx_line_clock_out = 1'b1;
    #2;
    rx_data_out = d;
    rx_valid_out = v;
    rx_sop_out = s;
    rx_eop_out = e;
    #60;
    rx_line_clock_out = 1'b0;
    #63;
  endtask

  // Slow mode inserts an idle line cycle before every byte
  task automatic send_frame(input logic [7:0] frm [$], input bit slow);
    int i;
    for (i = 0; i < frm.size(); i++) begin
      if (slow) begin
        line_cycle(~rx_data_out, 1'b0, 1'b0, 1'b0);
      end
      line_cycle(frm[i], 1'b1, i == 0, i == frm.size() - 1);
    end
    // Released data must not look like the last byte
    rx_data_out = ~rx_data_out;
    rx_valid_out = 1'b0;
    rx_eop_out = 1'b0;
  endtask
endmodule // rxepf_mac_model

// ==== test_rx_echo_packet_filter.sv ====
`timescale 1ns/1ns
`include "rxepf_params.svh"

module test_rx_echo_packet_filter;
  import rxepf_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        rx_line_clock_in;
  logic [7:0]  rx_data_in;
  logic        rx_valid_in;
  logic        rx_sop_in;
  logic        rx_eop_in;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  rxepf_ptr_t  slot_write_pointer_out;
  logic        slots_full_flag_out;
  int          fails = 0;
  int          checks = 0;
  int          cycles = 0;
  int          k;
  logic [31:0] exp_q [$];
  logic [7:0]  frm [$];
  logic        rd_seen = 1'b0;
  logic        fin = 1'b0;
  logic [47:0] sta;
  rxepf_ptr_t  rp = 4'h0;
  rxepf_ptr_t  wp = 4'h0;
  int          pos [7] = '{0, 0, 0, 12, 13, 14, 23};

  initial begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  rxepf_top rxepf_top_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .rx_line_clock_in(rx_line_clock_in), .rx_data_in(rx_data_in),
    .rx_valid_in(rx_valid_in), .rx_sop_in(rx_sop_in), .rx_eop_in(rx_eop_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .slot_write_pointer_out(slot_write_pointer_out),
    .slots_full_flag_out(slots_full_flag_out));
  rxepf_mac_model rxepf_mac_model_i (.rx_line_clock_out(rx_line_clock_in),
    .rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in), .rx_sop_out(rx_sop_in),
    .rx_eop_out(rx_eop_in));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_lvl(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t full and pointer %h expected %h", $time, got, exp);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk_in) rd_seen <= reg_rd_in;
  always @(negedge ref_clk_in) begin
    if (rd_seen && exp_q.size() > 0) begin
      cmp_rd(reg_rdata_out, exp_q.pop_front());
    end
  end

  // Hang guard, well above the longest expected run
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      print_verdict;
    end
  end

  // ----------------------------------------
  // Register bus and frame helpers
  // ----------------------------------------
  task automatic bus_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic bus_read(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
  endtask

  // Kind 0 unicast, 1 broadcast, 2..6 one header byte corrupted
  task automatic frame(input int kind, input bit slow);
    int i;
    rxepf_ptr_t p;
    logic [15:0] base;
    bit take;
    p = wp;
    take = (kind < 2) && (4'(wp - rp) != 4'h8);
    frm.delete();
    for (i = $urandom_range(120, 60); i > 0; i--) frm.push_back(8'($urandom));
    for (i = 0; i < 6; i++) frm[i] = (kind == 1) ? 8'hFF : sta[47 - 8 * i -: 8];
    frm[12] = 8'h08;
    frm[13] = 8'h00;
    frm[14] = 8'h45;
    frm[23] = 8'h01;
    if (kind > 1) begin
      i = (kind == 2) ? $urandom_range(5, 0) : pos[kind];
      frm[i] = frm[i] ^ (8'h01 << $urandom_range(7, 0));
    end
    rxepf_mac_model_i.send_frame(frm, slow);
    repeat (16) @(posedge ref_clk_in);
    if (take) wp = wp + 4'h1;
    fin = fin | take;
    cmp_lvl({slots_full_flag_out, slot_write_pointer_out}, {4'(wp - rp) == 4'h8, wp});
    bus_read(`RXEPF_PTR_OFS, {28'h0, wp});
    bus_read(`RXEPF_CMD_OFS, {fin, 31'h0});
    bus_write(`RXEPF_CMD_OFS, 32'h8000_0000);
    fin = 1'b0;
    if (take) begin
      base = 16'hC000 + {2'b00, p[2:0], 11'h000};
      bus_read(base, {frm[3], frm[2], frm[1], frm[0]});
      bus_read(base + 16'h0014, {frm[23], frm[22], frm[21], frm[20]});
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hae2c3f4d));
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    sta = {16'($urandom), $urandom};
    repeat (5) @(posedge ref_clk_in);
    cmp_lvl({slots_full_flag_out, slot_write_pointer_out}, 5'h00);
    bus_read(`RXEPF_CMD_OFS, 32'h0000_0000);
    bus_read(`RXEPF_PTR_OFS, 32'h0000_0000);
    bus_write(`RXEPF_STA_LO_OFS, sta[31:0]);
    bus_write(`RXEPF_STA_HI_OFS, {16'h0000, sta[47:32]});
    bus_read(`RXEPF_STA_LO_OFS, 32'h0000_0000);
    bus_read(16'h2108, 32'h0000_0000);
    $display("reset and register map test done");
    for (k = 0; k < 7; k++) frame(k, k[0]);
    $display("filter test done");
    while (4'(wp - rp) != 4'h8) frame(0, 1'b0);
    frame(1, 1'b1);
    rp = rp + 4'h1;
    bus_write(`RXEPF_PTR_OFS, {28'h0, rp});
    repeat (2) @(posedge ref_clk_in);
    cmp_lvl({slots_full_flag_out, slot_write_pointer_out}, {1'b0, wp});
    frame(0, 1'b1);
    rp = wp;
    bus_write(`RXEPF_PTR_OFS, {28'h0, rp});
    repeat (2) @(posedge ref_clk_in);
    cmp_lvl({slots_full_flag_out, slot_write_pointer_out}, {1'b0, wp});
    $display("ring full test done");
    repeat (4) @(posedge ref_clk_in);
    print_verdict;
  end
endmodule // test_rx_echo_packet_filter
